/* src/bgvm_map.vh */
// register map, field positions and timing counts of the battery gauge
// Notes on behaviour
// [RQ1] each conversion adds into charge or discharge 24-bit sum by sign; count++
// [RQ2] latest gauge conversion result stays readable in two's complement
// [RQ3] transfer request copies both sums and the counter to readable registers
// [RQ4] transfer request bit clears itself once the copy is done
// [RQ5] host waits about 250 us after a transfer request before reading
// [RQ6] a one on a clear bit resets its sum or the conversion counter
// [RQ7] clear written with transfer request acts only after the copy
// [RQ8] each clear bit returns to zero once its reset is done
// [RQ9] gauge offset calibration bit ties the two gauge converter inputs together
// [RQ10] one gauge conversion lasts 8192 ticks of the 32.768 kHz clock
// [RQ11] gauge off under power-on reset or reset pin low; enable resets to 0
// [RQ12] standby pin low stops the gauge at once, abandoning the conversion
// [RQ13] clearing gauge enable lets the running conversion finish first
// [RQ14] host takes remaining charge as charge sum minus discharge sum
// [RQ15] voltage monitor works only while its power-on bit is set
// [RQ16] monitor width select picks 7-bit or 12-bit conversions
// [RQ17] monitor ready flag rises once the converter is ready after power-on
// [RQ18] monitor start begins one conversion and clears itself at once
// [RQ19] running flag high during conversion; result readable when it drops
// [RQ20] monitor zero calibration bit grounds the voltage converter input
// [RQ21] 7-bit conversion takes 256 ticks, 12-bit takes 8192 ticks
// [RQ22] voltage monitor off under power-on reset or reset pin low
// [RQ23] reset pin restores control registers but keeps the sums
// [RQ24] sums and counter wrap modulo their width, independently
`ifndef BGVM_MAP_VH
`define BGVM_MAP_VH

// register offsets, byte wide registers
`define BGVM_OFS_GCTRL 8'h03
`define BGVM_OFS_CHG_LO 8'h04
`define BGVM_OFS_CHG_MI 8'h05
`define BGVM_OFS_CHG_HI 8'h06
`define BGVM_OFS_DIS_LO 8'h07
`define BGVM_OFS_DIS_MI 8'h08
`define BGVM_OFS_DIS_HI 8'h09
`define BGVM_OFS_SMP_LO 8'h10
`define BGVM_OFS_SMP_HI 8'h11
`define BGVM_OFS_CNT_LO 8'h12
`define BGVM_OFS_CNT_HI 8'h13
`define BGVM_OFS_VCTRL 8'h14
`define BGVM_OFS_VRES_LO 8'h15
`define BGVM_OFS_VRES_HI 8'h16

// gauge control fields
`define BGVM_G_ENABLE 0
`define BGVM_G_XFER 1
`define BGVM_G_CLR_CHG 2
`define BGVM_G_CLR_DIS 3
`define BGVM_G_CLR_CNT 4
`define BGVM_G_CAL 5

// monitor control fields
`define BGVM_V_POWER 0
`define BGVM_V_WIDE 1
`define BGVM_V_READY 2
`define BGVM_V_START 3
`define BGVM_V_RUN 4
`define BGVM_V_CAL 5

// reset values
`define BGVM_GCTRL_RST 8'h00
`define BGVM_VCTRL_RST 8'h00

// conversion lengths in 32.768 kHz ticks
`define BGVM_GAUGE_TICKS 14'h2000
`define BGVM_VMON7_TICKS 14'h0100
`define BGVM_VMON12_TICKS 14'h2000
// converter settling after power-on before ready
`define BGVM_VMON_SETTLE 14'h0004

`endif

/* src/bgvm_top.v */
// battery gauge accumulators, voltage monitor control and register port
`default_nettype none
`include "bgvm_map.vh"

module bgvm_top (
	input wire CORE_CLK_I, // 200 MHz core clock
	input wire RST_I, // synchronous reset, active high
	input wire CLK32K_I, // 32.768 kHz reference pin
	input wire RESET_PIN_N_I, // reset pin, active low
	input wire STANDBY_PIN_N_I, // standby pin, active low
	input wire POR_I, // battery under power-on-reset threshold
	input wire [12:0] GAUGE_SAMPLE_I, // gauge converter result, 2s compl
	input wire [11:0] VMON_SAMPLE_I, // voltage converter result
	input wire VMON_ANALOG_UP_I, // voltage converter settled
	input wire [7:0] ADDR_I, // register address
	input wire [7:0] WDATA_I, // write data
	input wire WR_I, // write strobe
	input wire RD_I, // read strobe
	output reg [7:0] RDATA_O, // read data, cycle after strobe
	output reg GAUGE_RUN_O, // gauge converter running
	output reg GAUGE_SHORT_O, // gauge inputs tied together
	output reg VMON_POWER_O, // voltage converter powered
	output reg VMON_GROUND_O, // voltage input grounded
	output reg VMON_CONVERT_O // voltage converter converting
);

	// sign extension of a gauge sample, used for both sums
	function [23:0] ext24;
		input [12:0] s;
		begin
			ext24 = {{11{s[12]}}, s};
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers

	reg [2:0] clk32_q;
	reg [1:0] rstn_q;
	reg [1:0] stbn_q;
	reg [1:0] por_q;
	reg [1:0] vup_q;
	reg [12:0] gs1_q;
	reg [12:0] gs2_q;
	reg [11:0] vs1_q;
	reg [11:0] vs2_q;

	// two flops on every pin; the third clk32 flop only feeds edge detect
	always @(posedge CORE_CLK_I)
	begin
		if (RST_I)
		begin
			clk32_q <= 3'b000;
			rstn_q <= 2'b00;
			stbn_q <= 2'b00;
			por_q <= 2'b11;
			vup_q <= 2'b00;
			gs1_q <= 13'h0000;
			gs2_q <= 13'h0000;
			vs1_q <= 12'h000;
			vs2_q <= 12'h000;
		end
		else
		begin
			clk32_q <= {clk32_q[1:0], CLK32K_I};
			rstn_q <= {rstn_q[0], RESET_PIN_N_I};
			stbn_q <= {stbn_q[0], STANDBY_PIN_N_I};
			por_q <= {por_q[0], POR_I};
			vup_q <= {vup_q[0], VMON_ANALOG_UP_I};
			gs1_q <= GAUGE_SAMPLE_I;
			gs2_q <= gs1_q;
			vs1_q <= VMON_SAMPLE_I;
			vs2_q <= vs1_q;
		end
	end

	// one core cycle enable per rising edge of the slow clock
	wire tick = clk32_q[1] & ~clk32_q[2];
	// pin reset or low battery puts control back to power-up values
	wire hold = ~rstn_q[1] | por_q[1]; // RQ11 RQ22 RQ23
	wire stb_n = stbn_q[1];

	////////////////////////////////////////////////////////////////////////
	// register writes

	wire wr_g = WR_I & (ADDR_I == `BGVM_OFS_GCTRL);
	wire wr_v = WR_I & (ADDR_I == `BGVM_OFS_VCTRL);

	reg g_en_q;
	reg g_xfer_q;
	reg g_clr_chg_q;
	reg g_clr_dis_q;
	reg g_clr_cnt_q;
	reg g_cal_q;
	reg v_pwr_q;
	reg v_wide_q;
	reg v_cal_q;

	// control bits; request and clear bits live for one cycle only
	always @(posedge CORE_CLK_I)
	begin
		if (RST_I | hold)
		begin
			g_en_q <= 1'b0; // RQ11 RQ23
			g_xfer_q <= 1'b0;
			g_clr_chg_q <= 1'b0;
			g_clr_dis_q <= 1'b0;
			g_clr_cnt_q <= 1'b0;
			g_cal_q <= 1'b0;
			v_pwr_q <= 1'b0;
			v_wide_q <= 1'b0;
			v_cal_q <= 1'b0;
		end
		else
		begin
			if (wr_g)
			begin
				g_en_q <= WDATA_I[`BGVM_G_ENABLE];
				g_cal_q <= WDATA_I[`BGVM_G_CAL];
			end
			// copy and clears are done in the cycle after the write
			g_xfer_q <= wr_g & WDATA_I[`BGVM_G_XFER]; // RQ4
			g_clr_chg_q <= wr_g & WDATA_I[`BGVM_G_CLR_CHG]; // RQ8
			g_clr_dis_q <= wr_g & WDATA_I[`BGVM_G_CLR_DIS]; // RQ8
			g_clr_cnt_q <= wr_g & WDATA_I[`BGVM_G_CLR_CNT]; // RQ8
			if (wr_v)
			begin
				v_pwr_q <= WDATA_I[`BGVM_V_POWER];
				v_wide_q <= WDATA_I[`BGVM_V_WIDE];
				v_cal_q <= WDATA_I[`BGVM_V_CAL];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// gas gauge conversion timing

	reg g_run_q;
	reg [13:0] g_tick_q;
	wire g_ok = stb_n & ~hold;
	wire g_end = g_run_q & tick & (g_tick_q == `BGVM_GAUGE_TICKS - 14'h0001);

	// a conversion is 8192 ticks; enable low only stops at the boundary
	always @(posedge CORE_CLK_I)
	begin
		if (RST_I | ~g_ok)
		begin
			g_run_q <= 1'b0; // RQ11 RQ12
			g_tick_q <= 14'h0000; // RQ12
		end
		else if (!g_run_q)
		begin
			g_run_q <= g_en_q;
			g_tick_q <= 14'h0000;
		end
		else if (tick)
		begin
			if (g_end)
			begin
				g_tick_q <= 14'h0000; // RQ10
				g_run_q <= g_en_q; // RQ13
			end
			else
				g_tick_q <= g_tick_q + 14'h0001;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// accumulators and snapshots

	reg [23:0] chg_q;
	reg [23:0] dis_q;
	reg [11:0] cnt_q;
	reg [12:0] smp_q;
	reg [23:0] chg_snap_q;
	reg [23:0] dis_snap_q;
	reg [11:0] cnt_snap_q;

	// sums survive the reset pin; only the core reset or a clear bit empties them
	always @(posedge CORE_CLK_I)
	begin
		if (RST_I)
		begin
			chg_q <= 24'h00_0000;
			dis_q <= 24'h00_0000;
			cnt_q <= 12'h000;
			smp_q <= 13'h0000;
		end
		else
		begin
			if (g_end)
				smp_q <= gs2_q; // RQ2
			// clears act after the snapshot below took the old value
			if (g_clr_chg_q)
				chg_q <= 24'h00_0000; // RQ6 RQ7
			else if (g_end & ~gs2_q[12])
				chg_q <= chg_q + ext24(gs2_q); // RQ1 RQ24
			if (g_clr_dis_q)
				dis_q <= 24'h00_0000; // RQ6 RQ7
			else if (g_end & gs2_q[12])
				dis_q <= dis_q - ext24(gs2_q); // RQ1 RQ24
			if (g_clr_cnt_q)
				cnt_q <= 12'h000; // RQ6 RQ7
			else if (g_end)
				cnt_q <= cnt_q + 12'h001; // RQ1 RQ24
		end
	end

	// snapshot copy well inside the eight slow-clock budget
	always @(posedge CORE_CLK_I)
	begin
		if (RST_I)
		begin
			chg_snap_q <= 24'h00_0000;
			dis_snap_q <= 24'h00_0000;
			cnt_snap_q <= 12'h000;
		end
		else if (g_xfer_q)
		begin
			chg_snap_q <= chg_q; // RQ3 RQ7
			dis_snap_q <= dis_q; // RQ3 RQ7
			cnt_snap_q <= cnt_q; // RQ3 RQ7
		end
	end

	////////////////////////////////////////////////////////////////////////
	// voltage monitor

	reg v_ready_q;
	reg v_run_q;
	reg [13:0] v_tick_q;
	reg [11:0] v_res_q;
	wire v_ok = v_pwr_q & ~hold; // RQ15 RQ22
	wire [13:0] v_len = v_wide_q ? `BGVM_VMON12_TICKS : `BGVM_VMON7_TICKS;
	wire v_go = wr_v & WDATA_I[`BGVM_V_START] & WDATA_I[`BGVM_V_POWER];
	wire v_last = tick & (v_tick_q == v_len - 14'h0001);

	// ready after the converter reports up and a short settle
	always @(posedge CORE_CLK_I)
	begin
		if (RST_I | ~v_ok)
		begin
			v_ready_q <= 1'b0; // RQ15
			v_run_q <= 1'b0; // RQ22
			v_tick_q <= 14'h0000;
		end
		else if (!v_ready_q)
		begin
			if (vup_q[1] & tick)
			begin
				if (v_tick_q == `BGVM_VMON_SETTLE - 14'h0001)
				begin
					v_ready_q <= 1'b1; // RQ17
					v_tick_q <= 14'h0000;
				end
				else
					v_tick_q <= v_tick_q + 14'h0001;
			end
		end
		else if (!v_run_q)
		begin
			// start is never stored, so it reads back as zero
			if (v_go)
				v_run_q <= 1'b1; // RQ18
			v_tick_q <= 14'h0000;
		end
		else if (tick)
		begin
			if (v_last)
			begin
				v_run_q <= 1'b0; // RQ19 RQ21
				v_tick_q <= 14'h0000;
			end
			else
				v_tick_q <= v_tick_q + 14'h0001; // RQ21
		end
	end

	// result latched in the same cycle the running flag falls
	always @(posedge CORE_CLK_I)
	begin
		if (RST_I)
			v_res_q <= 12'h000;
		else if (v_ok & v_ready_q & v_run_q & v_last)
		begin
			if (v_wide_q)
				v_res_q <= vs2_q; // RQ16 RQ19
			else
				v_res_q <= {5'h00, vs2_q[11:5]}; // RQ16 RQ19
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read port and analog controls

	reg [7:0] rd_d;

	// read mux; unmapped offsets read zero
	always @*
	begin
		rd_d = 8'h00;
		case (ADDR_I)
		`BGVM_OFS_GCTRL:
			rd_d = {2'b00, g_cal_q, g_clr_cnt_q, g_clr_dis_q, g_clr_chg_q,
				g_xfer_q, g_en_q};
		`BGVM_OFS_CHG_LO: rd_d = chg_snap_q[7:0];
		`BGVM_OFS_CHG_MI: rd_d = chg_snap_q[15:8];
		`BGVM_OFS_CHG_HI: rd_d = chg_snap_q[23:16];
		`BGVM_OFS_DIS_LO: rd_d = dis_snap_q[7:0];
		`BGVM_OFS_DIS_MI: rd_d = dis_snap_q[15:8];
		`BGVM_OFS_DIS_HI: rd_d = dis_snap_q[23:16];
		`BGVM_OFS_SMP_LO: rd_d = smp_q[7:0]; // RQ2
		`BGVM_OFS_SMP_HI: rd_d = {3'b000, smp_q[12:8]}; // RQ2
		`BGVM_OFS_CNT_LO: rd_d = cnt_snap_q[7:0];
		`BGVM_OFS_CNT_HI: rd_d = {4'h0, cnt_snap_q[11:8]};
		`BGVM_OFS_VCTRL:
			rd_d = {2'b00, v_cal_q, v_run_q, 1'b0, v_ready_q, v_wide_q,
				v_pwr_q};
		`BGVM_OFS_VRES_LO: rd_d = v_res_q[7:0];
		`BGVM_OFS_VRES_HI: rd_d = {4'h0, v_res_q[11:8]};
		default: rd_d = 8'h00;
		endcase
	end

	// outputs straight from flops, one cycle behind the state
	always @(posedge CORE_CLK_I)
	begin
		if (RST_I)
		begin
			RDATA_O <= 8'h00;
			GAUGE_RUN_O <= 1'b0;
			GAUGE_SHORT_O <= 1'b0;
			VMON_POWER_O <= 1'b0;
			VMON_GROUND_O <= 1'b0;
			VMON_CONVERT_O <= 1'b0;
		end
		else
		begin
			RDATA_O <= RD_I ? rd_d : 8'h00;
			GAUGE_RUN_O <= g_run_q;
			GAUGE_SHORT_O <= g_cal_q; // RQ9
			VMON_POWER_O <= v_ok; // RQ15
			VMON_GROUND_O <= v_cal_q & v_ok; // RQ20
			VMON_CONVERT_O <= v_run_q & v_ok; // RQ15 falls with power
		end
	end

endmodule
`default_nettype wire

/* tb/bgvm_asserts.sv */
// port-level checker of the gauge and monitor block
`default_nettype none
module bgvm_asserts (
	input wire CORE_CLK_I, // core clock
	input wire RST_I, // reset
	input wire RESET_PIN_N_I, // reset pin
	input wire STANDBY_PIN_N_I, // standby pin
	input wire POR_I, // power-on reset
	input wire [7:0] ADDR_I, // address
	input wire [7:0] WDATA_I, // write data
	input wire WR_I, // write strobe
	input wire RD_I, // read strobe
	input wire [7:0] RDATA_O, // read data
	input wire GAUGE_RUN_O, // gauge running
	input wire GAUGE_SHORT_O, // gauge inputs tied
	input wire VMON_POWER_O, // monitor powered
	input wire VMON_GROUND_O, // monitor grounded
	input wire VMON_CONVERT_O // monitor converting
);
	default clocking cb @(posedge CORE_CLK_I); endclocking
	default disable iff (RST_I);
	// read data shows only in the cycle after a read
	property p_rd_idle;
		!$past(RD_I) |-> RDATA_O == 8'h00;
	endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
	// sync flops give a few cycles of slack on the pins
	property p_stby;
		!STANDBY_PIN_N_I [*5] |-> !GAUGE_RUN_O;
	endproperty
	a_stby: assert property (p_stby) else $error("gauge runs in standby");
	property p_rpin;
		!RESET_PIN_N_I [*5] |-> !GAUGE_RUN_O && !VMON_POWER_O;
	endproperty
	a_rpin: assert property (p_rpin) else $error("active in reset");
	property p_por;
		POR_I [*5] |-> !GAUGE_RUN_O && !VMON_CONVERT_O;
	endproperty
	a_por: assert property (p_por) else $error("active under por");
	property p_short;
		WR_I && ADDR_I == 8'h03 && WDATA_I[5] && RESET_PIN_N_I && !POR_I
			|-> ##[1:3] GAUGE_SHORT_O;
	endproperty
	a_short: assert property (p_short) else $error("inputs not tied");
	property p_gnd;
		VMON_GROUND_O |-> VMON_POWER_O;
	endproperty
	a_gnd: assert property (p_gnd) else $error("ground while off");
	property p_conv;
		VMON_CONVERT_O |-> VMON_POWER_O;
	endproperty
	a_conv: assert property (p_conv) else $error("convert while off");
	property p_off;
		WR_I && ADDR_I == 8'h14 && !WDATA_I[0] |-> ##[1:3] !VMON_POWER_O;
	endproperty
	a_off: assert property (p_off) else $error("monitor stays on");
	property p_len;
		$rose(VMON_CONVERT_O) |-> VMON_CONVERT_O [*8];
	endproperty
	a_len: assert property (p_len) else $error("conversion too short");
endmodule
bind bgvm_top bgvm_asserts bgvm_asserts_i (.CORE_CLK_I(CORE_CLK_I),
	.RST_I(RST_I), .RESET_PIN_N_I(RESET_PIN_N_I), .POR_I(POR_I),
	.STANDBY_PIN_N_I(STANDBY_PIN_N_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I),
	.WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .GAUGE_RUN_O(GAUGE_RUN_O),
	.GAUGE_SHORT_O(GAUGE_SHORT_O), .VMON_POWER_O(VMON_POWER_O),
	.VMON_GROUND_O(VMON_GROUND_O), .VMON_CONVERT_O(VMON_CONVERT_O));
`default_nettype wire

/* tb/bgvm_conv_model.sv */
// converter and reference clock model facing the gauge pins
`default_nettype none
module bgvm_conv_model #(
	parameter logic [12:0] GSMP = 13'h0005, // gauge input level
	parameter logic [11:0] VSMP = 12'hABC // monitor input level
) (
	input wire logic clk_i, // core clock
	input wire logic short_i, // gauge inputs tied
	input wire logic power_i, // monitor powered
	input wire logic ground_i, // monitor input grounded
	output logic clk32k_o, // free running reference
	output logic [12:0] gsmp_o, // gauge result
	output logic [11:0] vsmp_o, // monitor result
	output logic up_o // converter settled
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [3:0] div_q = 4'h0;
	logic [3:0] set_q = 4'h0;
	logic ck_q = 1'b0;
	// single driver for the reference pin
	assign clk32k_o = ck_q;
	// reference runs free, sped up to 3 core cycles a half period
	always @(posedge clk_i)
	begin
		div_q <= (div_q == 4'h2) ? 4'h0 : div_q + 4'h1;
		if (div_q == 4'h2)
			ck_q <= !ck_q;
		set_q <= !power_i ? 4'h0 : (up_o ? set_q : set_q + 4'h1);
	end
	// settles ten cycles after power, drops at once without it
	assign up_o = set_q == 4'hA;
	// tied or grounded inputs read as zero
	assign gsmp_o = short_i ? 13'h0000 : GSMP;
	assign vsmp_o = ground_i ? 12'h000 : VSMP;
endmodule
`default_nettype wire

/* tb/bgvm_top_tb.sv */
// self-checking bench of the battery gauge block
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin fails++; \
	$display("mismatch t=%0t %h %h", $time, a, b); end end
module bgvm_top_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic rpin_n = 1'b1;
	logic stby_n = 1'b1;
	logic por = 1'b0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic [7:0] d;
	logic [7:0] e;
	int fails = 0;
	int n_tests = 0;
	int c;
	wire [7:0] rdata;
	wire grun, gshort, vpow, vgnd, vconv, c32k, up;
	wire [12:0] gs;
	wire [11:0] vs;
	bgvm_top bgvm_top_i (.CORE_CLK_I(clk), .RST_I(rst), .CLK32K_I(c32k),
		.RESET_PIN_N_I(rpin_n), .STANDBY_PIN_N_I(stby_n), .POR_I(por),
		.GAUGE_SAMPLE_I(gs), .VMON_SAMPLE_I(vs), .VMON_ANALOG_UP_I(up),
		.ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd),
		.RDATA_O(rdata), .GAUGE_RUN_O(grun), .GAUGE_SHORT_O(gshort),
		.VMON_POWER_O(vpow), .VMON_GROUND_O(vgnd), .VMON_CONVERT_O(vconv));
	bgvm_conv_model bgvm_conv_model_i (.clk_i(clk), .short_i(gshort),
		.power_i(vpow), .ground_i(vgnd), .clk32k_o(c32k), .gsmp_o(gs),
		.vsmp_o(vs), .up_o(up));
	initial forever #2.5 clk = !clk;
	////////////////////////////////////////////////////////////////////
	// one-cycle strobes, launched just after an edge
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= v;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 v = rdata;
	endtask
	// copy takes up to 8 ticks, 48 core cycles here
	task automatic xfer(input logic [7:0] v);
		wr_reg(8'h03, v);
		repeat (60) @(posedge clk);
	endtask
	////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		rd_reg(8'h03, d);
		`CHK(d, 8'h00)
		rd_reg(8'h14, d);
		`CHK(d, 8'h00)
		rd_reg(8'h30, d);
		`CHK(d, 8'h00)
	endtask
	// enable cleared mid-run: conversion completes, then snapshot
	task automatic t_gauge();
		wr_reg(8'h03, 8'h01);
		for (c = 0; c < 10 && grun !== 1'b1; c++) @(posedge clk);
		wr_reg(8'h03, 8'h00);
		`CHK(grun, 1'b1)
		for (c = 0; c < 60000 && grun === 1'b1; c++) @(posedge clk);
		`CHK(c > 49000 && c < 49200, 1'b1)
		xfer(8'h02);
		rd_reg(8'h03, d);
		`CHK(d, 8'h00)
		rd_reg(8'h04, e);
		`CHK(e, 8'h05)
		rd_reg(8'h07, d);
		`CHK(d, 8'h00)
		`CHK(e - d, 8'h05)
		rd_reg(8'h12, d);
		`CHK(d, 8'h01)
		rd_reg(8'h10, d);
		`CHK(d, 8'h05)
		// clear discharge and counter, keep the charge sum for later
		xfer(8'h1A);
		rd_reg(8'h03, d);
		`CHK(d, 8'h00)
		rd_reg(8'h12, d);
		`CHK(d, 8'h01)
		xfer(8'h02);
		rd_reg(8'h12, d);
		`CHK(d, 8'h00)
		rd_reg(8'h04, d);
		`CHK(d, 8'h05)
	endtask
	// standby stops a running gauge; reset pin and por follow while it is already stopped
	task automatic t_stop();
		wr_reg(8'h03, 8'h21);
		for (c = 0; c < 10 && grun !== 1'b1; c++) @(posedge clk);
		`CHK(gshort, 1'b1)
		stby_n <= 1'b0;
		repeat (6) @(posedge clk);
		`CHK(grun, 1'b0)
		stby_n <= 1'b1;
		rpin_n <= 1'b0;
		repeat (6) @(posedge clk);
		rpin_n <= 1'b1;
		por <= 1'b1;
		repeat (6) @(posedge clk);
		por <= 1'b0;
		repeat (4) @(posedge clk);
		rd_reg(8'h03, d);
		`CHK(d, 8'h00)
		// charge sum survives the pin reset, then a clear empties it
		xfer(8'h02);
		rd_reg(8'h04, d);
		`CHK(d, 8'h05)
		xfer(8'h06);
		xfer(8'h02);
		rd_reg(8'h04, d);
		`CHK(d, 8'h00)
	endtask
	task automatic t_vmon();
		d = 8'h00;
		wr_reg(8'h14, 8'h01);
		for (c = 0; c < 40 && d[2] !== 1'b1; c++) rd_reg(8'h14, d);
		`CHK(d[2], 1'b1)
		wr_reg(8'h14, 8'h09);
		rd_reg(8'h14, d);
		`CHK(d[4:3], 2'b10)
		for (c = 0; c < 2000 && vconv === 1'b1; c++) @(posedge clk);
		`CHK(c > 1500 && c < 1560, 1'b1)
		rd_reg(8'h15, d);
		`CHK(d, 8'h55)
		// wide run outlasts a narrow one, then power off abandons it
		wr_reg(8'h14, 8'h0B);
		repeat (1700) @(posedge clk);
		rd_reg(8'h14, d);
		`CHK(d[4:1], 4'b1011)
		wr_reg(8'h14, 8'h00);
		repeat (3) @(posedge clk);
		`CHK(vconv, 1'b0)
		rd_reg(8'h15, d);
		`CHK(d, 8'h55)
		wr_reg(8'h14, 8'h21);
		repeat (3) @(posedge clk);
		`CHK(vgnd, 1'b1)
		wr_reg(8'h14, 8'h00);
		repeat (3) @(posedge clk);
		`CHK(vpow, 1'b0)
	endtask
	////////////////////////////////////////////////////////////////////
	task automatic end_of_test();
		$display("tests %0d fails %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// main sequence after four reset cycles
	initial
	begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_gauge();
		t_stop();
		t_vmon();
		end_of_test();
	end
	// the run needs about 55k cycles
	initial
	begin
		#400000;
		fails++;
		end_of_test();
	end
endmodule
`default_nettype wire
